/* src/prog_device.sv */
// Purpose: device end of the serial program port: mode entry, erase, load, verify
// Assumes: programmer keeps its own timing; pins are asynchronous to clk
// Notes:   words are loaded lsb first; readback is offered once per session

module prog_device
  import prog_pkg::*;
#(
  parameter int SETUP_MIN = SETUP_MIN_CYC,
  parameter int SETUP_MAX = SETUP_MAX_CYC,
  parameter int BULK      = BULK_CYC,
  parameter int PROG      = PROG_CYC,
  parameter int DV_MIN    = DV_MIN_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  prog_port_if.dev                   port,
  output logic                       prog_mode,
  output logic                       verify_active,
  output logic [TOTAL_BITS-1:0]      mem_image
);
  typedef enum logic [2:0] {D_IDLE, D_ERASE, D_LOAD, D_PROG, D_VERIFY, D_DONE} dstate_t;

  dstate_t              st_q, st_d;
  logic [2:0]           ck_s_q, dt_s_q;
  logic                 ck_f_q, ck_p_q, dt_f_q, dt_p_q;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [3:0]           bitc_q, bitc_d;
  logic [3:0]           widx_q, widx_d;
  logic [7:0]           rd_q, rd_d;
  logic [WORD_BITS-1:0] word_q, word_d;
  logic                 pend_q, pend_d;
  logic                 out_q, out_d;
  logic [WORD_BITS-1:0] mem_q [NUM_WORDS];

  // -------------------------------------------------------------------
  // pin conditioning
  // -------------------------------------------------------------------
  // a level change is taken only once the 2nd and 3rd stages agree
  wire ck_f_d  = (ck_s_q[2] == ck_s_q[1]) ? ck_s_q[1] : ck_f_q;
  wire dt_f_d  = (dt_s_q[2] == dt_s_q[1]) ? dt_s_q[1] : dt_f_q;
  wire ck_rise = ck_f_q & ~ck_p_q;
  wire ck_fall = ~ck_f_q & ck_p_q;
  wire dt_rise = dt_f_q & ~dt_p_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ck_s_q <= 3'h0;
      dt_s_q <= 3'h0;
      ck_f_q <= 1'b0;
      ck_p_q <= 1'b0;
      dt_f_q <= 1'b0;
      dt_p_q <= 1'b0;
    end else begin
      ck_s_q <= {ck_s_q[1:0], port.prog_clock_pin};
      dt_s_q <= {dt_s_q[1:0], port.data_pin};
      ck_f_q <= ck_f_d;
      ck_p_q <= ck_f_q;
      dt_f_q <= dt_f_d;
      dt_p_q <= dt_f_q;
    end
  end

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire cnt_max   = (cnt_q == {CNT_W{1'b1}});
  wire setup_ok  = (cnt_q >= CNT_W'(SETUP_MIN)) && (cnt_q <= CNT_W'(SETUP_MAX));
  wire enter     = (st_q == D_IDLE) && ck_f_q && dt_rise && setup_ok;
  wire erase_end = (cnt_q == CNT_W'(BULK - 1));
  wire prog_end  = (cnt_q == CNT_W'(PROG - 1));
  wire dv_hit    = pend_q && (cnt_q == CNT_W'(DV_MIN - 1));
  wire wr_en     = (st_q == D_PROG) && prog_end;
  wire last_word = (widx_q == 4'(NUM_WORDS - 1));
  wire last_rd   = (rd_q == 8'(TOTAL_BITS));
  wire rd_bit    = mem_q[rd_q[7:4]][rd_q[3:0]];

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    bitc_d = bitc_q;
    widx_d = widx_q;
    rd_d   = rd_q;
    word_d = word_q;
    pend_d = pend_q;
    out_d  = out_q;
    case (st_q)
      D_IDLE: begin
        // measure how long the clock pin has stood high
        cnt_d = ck_f_q ? (cnt_max ? cnt_q : cnt_q + 1'b1) : '0;
        if (enter) begin
          st_d   = D_ERASE;
          cnt_d  = '0;
          bitc_d = 4'h0;
          widx_d = 4'h0;
        end
      end
      D_ERASE: begin
        // data arriving before this ends is ignored
        cnt_d = cnt_q + 1'b1;
        if (erase_end) begin
          st_d  = D_LOAD;
          cnt_d = '0;
        end
      end
      D_LOAD: begin
        if (ck_rise) begin
          word_d = {dt_f_q, word_q[WORD_BITS-1:1]};
          bitc_d = bitc_q + 1'b1;
          if (bitc_q == 4'hF) begin
            st_d  = D_PROG;
            cnt_d = '0;
          end
        end
      end
      D_PROG: begin
        // clock edges during the program cycle are not taken
        cnt_d = cnt_q + 1'b1;
        if (prog_end) begin
          cnt_d  = '0;
          widx_d = widx_q + 1'b1;
          st_d   = last_word ? D_VERIFY : D_LOAD;
          rd_d   = 8'h00;
          pend_d = 1'b0;
          out_d  = 1'b0;
        end
      end
      D_VERIFY: begin
        cnt_d = pend_q ? cnt_q + 1'b1 : '0;
        if (ck_rise && !last_rd) begin
          pend_d = 1'b1;
          cnt_d  = '0;
        end else if (dv_hit) begin
          out_d  = rd_bit;
          rd_d   = rd_q + 1'b1;
          pend_d = 1'b0;
        end else if (ck_fall && last_rd) begin
          st_d = D_DONE;
        end
      end
      D_DONE: begin
        // readback is not offered again until a new session is entered
        cnt_d = '0;
        out_d = 1'b0;
        if (!ck_f_q) begin
          st_d = D_IDLE;
        end
      end
      default: st_d = D_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= D_IDLE;
      cnt_q  <= '0;
      bitc_q <= 4'h0;
      widx_q <= 4'h0;
      rd_q   <= 8'h00;
      word_q <= '0;
      pend_q <= 1'b0;
      out_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bitc_q <= bitc_d;
      widx_q <= widx_d;
      rd_q   <= rd_d;
      word_q <= word_d;
      pend_q <= pend_d;
      out_q  <= out_d;
    end
  end

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
    always_ff @(posedge clk) begin
      if (rst || enter) begin
        mem_q[g] <= '0;
      end else if (wr_en && (widx_q == 4'(g))) begin
        mem_q[g] <= word_q;
      end
    end
    assign mem_image[g*WORD_BITS +: WORD_BITS] = mem_q[g];
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // the pin is driven only in verify, so a plain readback cannot happen
  assign port.dev_data_out = out_q;
  assign port.dev_data_oe  = (st_q == D_VERIFY);
  assign prog_mode         = (st_q != D_IDLE) && (st_q != D_DONE);
  assign verify_active     = (st_q == D_VERIFY);
endmodule : prog_device

/* src/prog_pkg.sv */
// Purpose: shared timing and layout constants for the serial program port
// Assumes: 50 MHz system clock on both ends
// Notes:   times keep their printed unit; cycle counts are derived from them
package prog_pkg;
  localparam real CLK_MHZ          = 50.0;
  // -------------------------------------------------------------------
  // storage layout
  // -------------------------------------------------------------------
  localparam int  WORD_BITS        = 16;
  localparam int  NUM_WORDS        = 12;
  localparam int  TOTAL_BITS       = 192;
  localparam int  CNT_W            = 22;
  // -------------------------------------------------------------------
  // printed times
  // -------------------------------------------------------------------
  localparam real MODE_ENTRY_SETUP_MIN_MS = 3.5;
  localparam real MODE_ENTRY_SETUP_MAX_MS = 4.5;
  localparam real MODE_ENTRY_SETUP_USE_MS = 4.0;
  localparam real BULK_ERASE_WAIT_MS      = 2.2;
  localparam real PROG_CYCLE_MS           = 36.0;
  localparam real CLK_HALF_MIN_US         = 25.0;
  localparam real DATA_VALID_MIN_US       = 10.0;
  localparam real DATA_VALID_MAX_US       = 24.0;
  // -------------------------------------------------------------------
  // derived cycle counts
  // -------------------------------------------------------------------
  localparam int SETUP_MIN_CYC = int'($ceil(MODE_ENTRY_SETUP_MIN_MS * 1000.0 * CLK_MHZ));
  localparam int SETUP_MAX_CYC = int'($floor(MODE_ENTRY_SETUP_MAX_MS * 1000.0 * CLK_MHZ));
  localparam int SETUP_USE_CYC = int'($ceil(MODE_ENTRY_SETUP_USE_MS * 1000.0 * CLK_MHZ));
  localparam int BULK_CYC      = int'($floor(BULK_ERASE_WAIT_MS * 1000.0 * CLK_MHZ));
  localparam int PROG_CYC      = int'($floor(PROG_CYCLE_MS * 1000.0 * CLK_MHZ));
  localparam int HALF_CYC      = int'($ceil(CLK_HALF_MIN_US * CLK_MHZ));
  localparam int DV_MIN_CYC    = int'($ceil(DATA_VALID_MIN_US * CLK_MHZ));
  localparam int DV_MAX_CYC    = int'($floor(DATA_VALID_MAX_US * CLK_MHZ));
endpackage : prog_pkg

/* src/prog_port_if.sv */
// Purpose: two-pin program link between device and programmer
// Assumes: only one end enables the data pin at a time
// Notes:   the data pin idles low, as if weakly pulled down
interface prog_port_if;
  logic prog_clock_pin;
  logic dev_data_out;
  logic dev_data_oe;
  logic prg_data_out;
  logic prg_data_oe;
  logic data_pin;

  assign data_pin = dev_data_oe ? dev_data_out : (prg_data_oe ? prg_data_out : 1'b0);

  modport dev (input prog_clock_pin, input data_pin, output dev_data_out, output dev_data_oe);
  modport prg (output prog_clock_pin, output prg_data_out, output prg_data_oe, input data_pin);
endinterface : prog_port_if

/* src/prog_programmer.sv */
// Purpose: programmer end: drives mode entry, writes 192 bits, reads them back
// Assumes: one session per start pulse; device shares the same timing
// Notes:   the link clock is divided from clk and driven out
module prog_programmer
  import prog_pkg::*;
#(
  parameter int SETUP = SETUP_USE_CYC,
  parameter int BULK  = BULK_CYC,
  parameter int PROG  = PROG_CYC,
  parameter int HALF  = HALF_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  prog_port_if.prg                   port,
  input  wire logic                  start,
  input  wire logic [TOTAL_BITS-1:0] wdata,
  output logic                       ready,
  output logic                       done,
  output logic [TOTAL_BITS-1:0]      rdata
);
  typedef enum logic [3:0] {P_IDLE, P_SETUP, P_ENTRY, P_LOW, P_HIGH, P_PROG,
                            P_VLOW, P_VHIGH, P_DONE} pstate_t;

  pstate_t               st_q;
  logic [CNT_W-1:0]      cnt_q;
  logic [7:0]            bit_q;
  logic [TOTAL_BITS-1:0] wr_q;
  logic [TOTAL_BITS-1:0] rd_q;
  logic                  ck_q, dat_q, oe_q;
  logic [2:0]            dt_s_q;
  logic                  dt_f_q;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire dt_f_d    = (dt_s_q[2] == dt_s_q[1]) ? dt_s_q[1] : dt_f_q;
  wire setup_end = (cnt_q == CNT_W'(SETUP - 1));
  wire bulk_end  = (cnt_q == CNT_W'(BULK - 1));
  wire half_end  = (cnt_q == CNT_W'(HALF - 1));
  wire prog_end  = (cnt_q == CNT_W'(PROG - 1));
  wire word_end  = (bit_q[3:0] == 4'hF);
  wire all_sent  = (bit_q == 8'(TOTAL_BITS));
  wire last_rd   = (bit_q == 8'(TOTAL_BITS - 1));
  wire cur_bit   = all_sent ? 1'b0 : wr_q[bit_q];

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= P_IDLE;
      cnt_q <= '0;
      bit_q <= 8'h00;
      wr_q  <= '0;
      rd_q  <= '0;
      ck_q  <= 1'b0;
      dat_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        P_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            wr_q  <= wdata;
            bit_q <= 8'h00;
            ck_q  <= 1'b1;
            dat_q <= 1'b0;
            oe_q  <= 1'b1;
            st_q  <= P_SETUP;
          end
        end
        P_SETUP: if (setup_end) begin
          dat_q <= 1'b1;
          cnt_q <= '0;
          st_q  <= P_ENTRY;
        end
        P_ENTRY: if (bulk_end) begin
          // first bit only after the erase has had its full time
          ck_q  <= 1'b0;
          dat_q <= cur_bit;
          cnt_q <= '0;
          st_q  <= P_LOW;
        end
        P_LOW: if (half_end) begin
          ck_q  <= 1'b1;
          cnt_q <= '0;
          st_q  <= P_HIGH;
        end
        P_HIGH: if (half_end) begin
          ck_q  <= 1'b0;
          bit_q <= bit_q + 1'b1;
          cnt_q <= '0;
          st_q  <= word_end ? P_PROG : P_LOW;
          if (!word_end) begin
            dat_q <= wr_q[bit_q + 8'h01];
          end
          // let go of the pin before the device can start driving it
          if (word_end && last_rd) begin
            oe_q <= 1'b0;
          end
        end
        P_PROG: if (prog_end) begin
          cnt_q <= '0;
          if (all_sent) begin
            oe_q  <= 1'b0;
            bit_q <= 8'h00;
            st_q  <= P_VLOW;
          end else begin
            dat_q <= cur_bit;
            st_q  <= P_LOW;
          end
        end
        P_VLOW: if (half_end) begin
          ck_q  <= 1'b1;
          cnt_q <= '0;
          st_q  <= P_VHIGH;
        end
        P_VHIGH: if (half_end) begin
          // half period exceeds the longest data valid time
          rd_q[bit_q] <= dt_f_q;
          ck_q  <= 1'b0;
          bit_q <= bit_q + 1'b1;
          cnt_q <= '0;
          st_q  <= last_rd ? P_DONE : P_VLOW;
        end
        P_DONE: begin
          dat_q <= 1'b0;
          st_q  <= P_IDLE;
        end
        default: st_q <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dt_s_q <= 3'h0;
      dt_f_q <= 1'b0;
    end else begin
      dt_s_q <= {dt_s_q[1:0], port.data_pin};
      dt_f_q <= dt_f_d;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign port.prog_clock_pin = ck_q;
  assign port.prg_data_out   = dat_q;
  assign port.prg_data_oe    = oe_q;
  assign ready               = (st_q == P_IDLE);
  assign done                = (st_q == P_DONE);
  assign rdata               = rd_q;
endmodule : prog_programmer

/* sim/prog_port_monitor.sv */
// Purpose: assertions on the two-pin program link between device and programmer
// Assumes: both ends run on clk; pins are sampled raw here, not filtered
// Notes:   parameters must match the device instance
module prog_port_monitor
  import prog_pkg::*;
#(
  parameter int SETUP_MIN = SETUP_MIN_CYC,
  parameter int SETUP_MAX = SETUP_MAX_CYC,
  parameter int BULK      = BULK_CYC,
  parameter int PROG      = PROG_CYC,
  parameter int HALF      = HALF_CYC,
  parameter int DV_MIN    = DV_MIN_CYC,
  parameter int DV_MAX    = DV_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_clock_pin,
  input wire logic dev_data_out,
  input wire logic dev_data_oe,
  input wire logic prg_data_out,
  input wire logic prg_data_oe,
  input wire logic data_pin
);
  // -----------------------------------------------------------------
  // helper counters
  // -----------------------------------------------------------------
  // counters saturate nowhere: one session stays far below 2^31 cycles
  int   hi_q;
  int   lo_q;
  int   bits_q;
  logic pin_q;
  logic poe_q;
  wire  pin_rise = prog_clock_pin && !pin_q;
  wire  oe_held  = prg_data_oe && poe_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      hi_q   <= 0;
      lo_q   <= 0;
      bits_q <= 0;
      pin_q  <= 1'b0;
      poe_q  <= 1'b0;
    end else begin
      hi_q  <= prog_clock_pin ? hi_q + 1 : 0;
      lo_q  <= prog_clock_pin ? 0 : lo_q + 1;
      pin_q <= prog_clock_pin;
      poe_q <= prg_data_oe;
      if (prg_data_oe && !poe_q) begin
        bits_q <= 0;
      end else if (pin_rise && oe_held) begin
        bits_q <= bits_q + 1;
      end
    end
  end

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence entry_seq;
    prog_clock_pin && $rose(data_pin) && !dev_data_oe;
  endsequence
  sequence word_end_seq;
    $rose(prog_clock_pin) && oe_held && bits_q > 0 && bits_q % WORD_BITS == 0;
  endsequence

  AST_ENTRY_WINDOW: assert property (entry_seq |-> hi_q >= SETUP_MIN && hi_q <= SETUP_MAX)
    else $error("mode entry outside setup window");
  AST_ERASE_WAIT: assert property ($fell(prog_clock_pin) && prg_data_oe && bits_q == 0
    |-> hi_q >= SETUP_MIN + BULK) else $error("first bit before bulk erase wait");
  AST_HIGH_MIN: assert property ($fell(prog_clock_pin) |-> hi_q >= HALF)
    else $error("link clock high phase too short");
  AST_LOW_MIN: assert property ($rose(prog_clock_pin) && oe_held |-> lo_q >= HALF)
    else $error("link clock low phase too short");
  AST_DATA_HOLD: assert property ($rose(prog_clock_pin) && prg_data_oe
    |=> $stable(prg_data_out) [*8]) else $error("write data moved after clock rise");
  AST_PROG_WAIT: assert property (word_end_seq |-> lo_q >= PROG)
    else $error("clock resumed inside program cycle");
  AST_ONE_DRIVER: assert property (!(dev_data_oe && prg_data_oe))
    else $error("both ends drive the data pin");
  AST_DV_TIME: assert property (dev_data_oe && $changed(dev_data_out)
    |-> prog_clock_pin && hi_q >= DV_MIN && hi_q <= DV_MAX)
    else $error("verify bit outside valid window");
  AST_VERIFY_AFTER_LOAD: assert property ($rose(dev_data_oe) |-> bits_q == TOTAL_BITS)
    else $error("readback without full programming");
  cover property (entry_seq);
endmodule : prog_port_monitor

/* sim/encoder_eeprom_program_port_test.sv */
// Purpose: two program and verify sessions across both ends of the link
// Assumes: shortened setup, erase, program, bit and data valid counts
// Notes:   two sessions take about seventy thousand clock cycles
module encoder_eeprom_program_port_test;
  import prog_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  start = 1'b0;
  logic [TOTAL_BITS-1:0] wdata = '0;
  logic [TOTAL_BITS-1:0] rdata;
  logic [TOTAL_BITS-1:0] mem_image;
  logic [TOTAL_BITS-1:0] exp_q[$];
  logic                  ready;
  logic                  done;
  logic                  prog_mode;
  logic                  verify_active;
  logic                  mode_q = 1'b0;
  int                    failures = 0;
  int                    comparisons = 0;
  int                    seed = 11;
  // shortened times keep the order of the real ones: setup inside the window,
  // bit half period longer than the latest data valid point
  localparam int T_SETUP_MIN = 200;
  localparam int T_SETUP_MAX = 300;
  localparam int T_SETUP     = 250;
  localparam int T_BULK      = 100;
  localparam int T_PROG_DEV  = 200;
  localparam int T_PROG_PRG  = 300;
  localparam int T_HALF      = 40;
  localparam int T_DV_MIN    = 16;
  localparam int T_DV_MAX    = 32;

  always #10 clk = ~clk;

  prog_port_if u_prog_port_if ();
  prog_device #(.SETUP_MIN(T_SETUP_MIN), .SETUP_MAX(T_SETUP_MAX), .BULK(T_BULK),
                .PROG(T_PROG_DEV), .DV_MIN(T_DV_MIN)) u_prog_device (
    .clk(clk), .rst(rst), .port(u_prog_port_if.dev), .prog_mode(prog_mode),
    .verify_active(verify_active), .mem_image(mem_image));
  prog_programmer #(.SETUP(T_SETUP), .BULK(T_BULK), .PROG(T_PROG_PRG), .HALF(T_HALF))
  u_prog_programmer (
    .clk(clk), .rst(rst), .port(u_prog_port_if.prg), .start(start), .wdata(wdata),
    .ready(ready), .done(done), .rdata(rdata));
  prog_port_monitor #(.SETUP_MIN(T_SETUP_MIN), .SETUP_MAX(T_SETUP_MAX), .BULK(T_BULK),
                      .PROG(T_PROG_DEV), .HALF(T_HALF), .DV_MIN(T_DV_MIN),
                      .DV_MAX(T_DV_MAX))
  u_prog_port_monitor (
    .clk(clk), .rst(rst), .prog_clock_pin(u_prog_port_if.prog_clock_pin),
    .dev_data_out(u_prog_port_if.dev_data_out), .dev_data_oe(u_prog_port_if.dev_data_oe),
    .prg_data_out(u_prog_port_if.prg_data_out), .prg_data_oe(u_prog_port_if.prg_data_oe),
    .data_pin(u_prog_port_if.data_pin));

  task automatic check(input string what, input logic [TOTAL_BITS-1:0] seen,
                       input logic [TOTAL_BITS-1:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic finish_session();
    int k;
    for (k = 0; k < 50000 && done !== 1'b1; k++) begin
      @(negedge clk);
    end
    if (k >= 50000) begin
      failures++;
      $display("mismatch session timeout expected done seen none");
      give_verdict();
    end
    // the device leaves verify a few cycles after the last clock fall
    repeat (10) @(negedge clk);
    check("ready after", TOTAL_BITS'(ready), TOTAL_BITS'(1'b1));
    check("prog_mode after", TOTAL_BITS'(prog_mode), '0);
    check("verify_active after", TOTAL_BITS'(verify_active), '0);
    check("data pin idle", TOTAL_BITS'(u_prog_port_if.data_pin), '0);
    check("results left", TOTAL_BITS'(exp_q.size()), '0);
  endtask : finish_session

  // -----------------------------------------------------------------
  // result watcher
  // -----------------------------------------------------------------
  always @(negedge clk) begin
    mode_q <= prog_mode;
    if (prog_mode === 1'b1 && mode_q !== 1'b1) begin
      check("mem_image at entry", mem_image, '0);
    end
    if (done === 1'b1) begin
      if (exp_q.size() > 0) begin
        check("rdata", rdata, exp_q[0]);
        check("verify_active at done", TOTAL_BITS'(verify_active), TOTAL_BITS'(1'b1));
        check("mem_image", mem_image, exp_q.pop_front());
      end else begin
        check("extra done", TOTAL_BITS'(done), '0);
      end
    end
  end

  // -----------------------------------------------------------------
  // stimulus
  // -----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check("ready after reset", TOTAL_BITS'(ready), TOTAL_BITS'(1'b1));
    check("data pin after reset", TOTAL_BITS'(u_prog_port_if.data_pin), '0);
    // the second session must find the first one's contents erased on entry
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        wdata[32*i +: 32] = $random(seed);
      end
      start = 1'b1;
      exp_q.push_back(wdata);
      @(negedge clk) start = 1'b0;
      // a start mid-session must be ignored, with other data offered
      repeat (1000) @(negedge clk);
      check("ready in session", TOTAL_BITS'(ready), '0);
      start = 1'b1;
      wdata = ~wdata;
      @(negedge clk) start = 1'b0;
      finish_session();
      $display("test session %0d done", s);
    end
    give_verdict();
  end
endmodule : encoder_eeprom_program_port_test
